// ==== design/frpp_top.sv ====
// module: flash row program sequencer with block protection, AXI4-Lite registers
//
// Summary of operation
// R01 - program one aligned 32-byte row at a time
// R02 - program select enables address/data capture
// R03 - software reads protect byte before high voltage
// R04 - software writes once inside row to select
// R05 - software waits setup delay before high voltage
// R06 - software waits, writes bytes, waits per byte
// R07 - software repeats byte writes for whole row
// R08 - software keeps intervals below maximum program time
// R09 - finish: clear select, hold, clear high voltage
// R10 - software runs from RAM, keeps step order
// R11 - refuse high voltage for protected addresses
// R12 - protect start is 11, field, six zeros
// R13 - all zeros locks all, ones opens all
// R14 - BC00 to BFFF locked unless field all ones
// R15 - protected range changes only with test voltage; the code leaves the protect byte programmable while the field is all ones
// R16 - protect byte not writable by bus write
// R17 - high voltage only after select and steps
// R18 - program and erase select never both set
// R19 - erased bit reads one, programmed reads zero
// R20 - ignore high voltage without read and row write
module frpp_top (
  input wire logic REF_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic AXI_AWVALID_IN,
  output logic AXI_AWREADY_OUT,
  input wire logic [frpp_pkg::AXI_ADDR_W-1:0] AXI_AWADDR_IN,
  input wire logic AXI_WVALID_IN,
  output logic AXI_WREADY_OUT,
  input wire logic [31:0] AXI_WDATA_IN,
  input wire logic [3:0] AXI_WSTRB_IN,
  output logic AXI_BVALID_OUT,
  input wire logic AXI_BREADY_IN,
  output logic [1:0] AXI_BRESP_OUT,
  input wire logic AXI_ARVALID_IN,
  output logic AXI_ARREADY_OUT,
  input wire logic [frpp_pkg::AXI_ADDR_W-1:0] AXI_ARADDR_IN,
  output logic AXI_RVALID_OUT,
  input wire logic AXI_RREADY_IN,
  output logic [31:0] AXI_RDATA_OUT,
  output logic [1:0] AXI_RRESP_OUT,
  input wire logic [frpp_pkg::FL_DATA_W-1:0] PROTECT_START_BYTE_IN,
  input wire logic TEST_HIGH_VOLTAGE_IN,
  output logic [frpp_pkg::FL_ADDR_W-1:0] ARRAY_ADDR_OUT,
  output logic [frpp_pkg::FL_DATA_W-1:0] ARRAY_DATA_OUT,
  output logic ARRAY_WRITE_STB_OUT,
  output logic PROGRAM_SELECT_OUT,
  output logic ERASE_SELECT_OUT,
  output logic MASS_SELECT_OUT,
  output logic HIGH_VOLTAGE_ENABLE_OUT,
  output logic ARRAY_READABLE_OUT
);
  import frpp_pkg::*;

  frpp_tmr_if tif ();

  frpp_timer u_timer (
    .clk_in(REF_CLK_IN),
    .rst_in(SYS_RST_IN),
    .tif(tif)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // protection decode: start address from field, low block, protect byte itself
  function automatic logic addr_locked(input logic [15:0] a, input logic [7:0] pb);
    logic [15:0] start;
    start = {PROT_TOP_BITS, pb, PROT_LOW_ZERO}; // [R12]
    if (pb == PROT_ALL_OPEN) begin
      return 1'b0; // [R13]
    end
    if (pb == PROT_ALL_LOCK) begin
      return 1'b1; // [R13]
    end
    return (a >= start) || ((a >= LOW_BLOCK_LO) && (a <= LOW_BLOCK_HI)) // [R11] [R14]
      || (a == PROTECT_BYTE_ADDR); // [R15]
  endfunction : addr_locked

  ////////////////////////////////////////////////////////////////////////////////
  // test voltage pin: three flops, change taken when second and third agree
  logic [2:0] tv_sync_reg;
  logic tv_reg;
  logic tv_next;

  always_comb begin
    tv_next = tv_reg;
    if (tv_sync_reg[1] == tv_sync_reg[2]) begin
      tv_next = tv_sync_reg[2];
    end
  end

  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      tv_sync_reg <= 3'h0;
      tv_reg <= 1'b0;
    end else begin
      tv_sync_reg <= {tv_sync_reg[1:0], TEST_HIGH_VOLTAGE_IN};
      tv_reg <= tv_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: one write and one read at a time
  logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic [AXI_ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next, rdata_reg, rdata_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic do_wr, ctrl_wr, status_wr, flash_wr, prot_rd;
  logic [AXI_ADDR_W-1:0] wa, ra;
  logic [31:0] status_word;

  frpp_state_t state_reg, state_next;
  logic pgm_reg, pgm_next, erase_reg, erase_next, mass_reg, mass_next;
  logic hv_reg, hv_next, refused_reg, refused_next, stb_reg, stb_next;
  logic [FL_ADDR_W-1:0] row_reg, row_next, arr_addr_reg, arr_addr_next;
  logic [FL_DATA_W-1:0] arr_data_reg, arr_data_next;

  assign AXI_AWREADY_OUT = !aw_full_reg;
  assign AXI_WREADY_OUT = !w_full_reg;
  assign AXI_ARREADY_OUT = !rvalid_reg;
  assign AXI_BVALID_OUT = bvalid_reg;
  assign AXI_BRESP_OUT = bresp_reg;
  assign AXI_RVALID_OUT = rvalid_reg;
  assign AXI_RDATA_OUT = rdata_reg;
  assign AXI_RRESP_OUT = rresp_reg;

  // decoded register events
  assign wa = aw_addr_reg & WORD_MASK;
  assign ra = AXI_ARADDR_IN & WORD_MASK;
  assign do_wr = aw_full_reg && w_full_reg && !bvalid_reg;
  assign ctrl_wr = do_wr && (wa == OFF_CTRL) && w_strb_reg[0];
  assign status_wr = do_wr && (wa == OFF_STATUS) && w_strb_reg[0];
  assign flash_wr = do_wr && (wa == OFF_FLASH_WR) && ((w_strb_reg & FW_STRB_NEED) == FW_STRB_NEED);
  assign prot_rd = AXI_ARVALID_IN && !rvalid_reg && (ra == OFF_PROTECT);

  always_comb begin
    status_word = '0;
    status_word[ST_STATE_LSB +: 3] = state_reg;
    status_word[ST_BUSY_BIT] = tif.busy;
    status_word[ST_REFUSED_BIT] = refused_reg;
    status_word[ST_READY_BIT] = ARRAY_READABLE_OUT;
    status_word[ST_TESTV_BIT] = tv_reg;
  end

  // channel handshakes, write response and read mux
  always_comb begin
    aw_full_next = aw_full_reg;
    aw_addr_next = aw_addr_reg;
    w_full_next = w_full_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (AXI_AWVALID_IN && !aw_full_reg) begin
      aw_full_next = 1'b1;
      aw_addr_next = AXI_AWADDR_IN;
    end
    if (AXI_WVALID_IN && !w_full_reg) begin
      w_full_next = 1'b1;
      w_data_next = AXI_WDATA_IN;
      w_strb_next = AXI_WSTRB_IN;
    end
    if (bvalid_reg && AXI_BREADY_IN) begin
      bvalid_next = 1'b0;
    end
    if (do_wr) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      // protect byte lives in the array: a bus write is refused [R16]
      bresp_next = (wa == OFF_CTRL || wa == OFF_STATUS || wa == OFF_FLASH_WR) ?
        RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid_reg && AXI_RREADY_IN) begin
      rvalid_next = 1'b0;
    end
    if (AXI_ARVALID_IN && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      rdata_next = '0;
      case (ra)
        OFF_CTRL: begin
          rdata_next[CTRL_PGM_BIT] = pgm_reg;
          rdata_next[CTRL_ERASE_BIT] = erase_reg;
          rdata_next[CTRL_MASS_BIT] = mass_reg;
          rdata_next[CTRL_HV_BIT] = hv_reg;
        end
        OFF_STATUS: rdata_next = status_word;
        OFF_PROTECT: rdata_next[FL_DATA_W-1:0] = PROTECT_START_BYTE_IN;
        OFF_FLASH_WR: rdata_next = '0;
        default: rresp_next = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_full_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else begin
      aw_full_reg <= aw_full_next;
      aw_addr_reg <= aw_addr_next;
      w_full_reg <= w_full_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer: select, protect read, row select, high voltage, hold, recovery
  logic w_pgm, w_erase, w_hv, locked;
  logic [FL_ADDR_W-1:0] fw_addr;
  logic [FL_DATA_W-1:0] fw_data;

  assign w_pgm = w_data_reg[CTRL_PGM_BIT];
  assign w_erase = w_data_reg[CTRL_ERASE_BIT];
  assign w_hv = w_data_reg[CTRL_HV_BIT];
  assign fw_addr = w_data_reg[FW_ADDR_LSB +: FL_ADDR_W];
  assign fw_data = w_data_reg[FW_DATA_LSB +: FL_DATA_W];
  // mass erase touches everything, so any lock refuses it; test voltage overrides
  assign locked = !tv_reg && (mass_reg ? (PROTECT_START_BYTE_IN != PROT_ALL_OPEN)
    : addr_locked(row_reg, PROTECT_START_BYTE_IN)); // [R11] [R15]

  always_comb begin
    state_next = state_reg;
    pgm_next = pgm_reg;
    erase_next = erase_reg;
    mass_next = mass_reg;
    hv_next = hv_reg;
    row_next = row_reg;
    arr_addr_next = arr_addr_reg;
    arr_data_next = arr_data_reg;
    refused_next = refused_reg;
    stb_next = 1'b0;
    tif.start = 1'b0;
    tif.load = RCV_CYC;
    if (status_wr && w_data_reg[ST_REFUSED_BIT]) begin
      refused_next = 1'b0; // write one to clear, a new refusal below wins
    end
    if (prot_rd && state_reg == S_SEL) begin
      state_next = S_PREAD; // [R20]
    end
    if (flash_wr) begin
      if (state_reg == S_PREAD) begin
        row_next = fw_addr; // [R02] [R20]
        arr_addr_next = fw_addr;
        arr_data_next = erase_reg ? ERASED_BYTE : fw_data; // [R19]
        state_next = S_ROW;
        tif.start = 1'b1;
        tif.load = SETUP_CYC;
      end else if (state_reg == S_HV && pgm_reg) begin
        if (fw_addr[FL_ADDR_W-1:ROW_LSB] == row_reg[FL_ADDR_W-1:ROW_LSB]) begin
          arr_addr_next = fw_addr; // [R01]
          arr_data_next = fw_data; // [R19]
          stb_next = 1'b1;
          tif.start = 1'b1;
          tif.load = PROG_CYC;
        end else begin
          refused_next = 1'b1; // [R01]
        end
      end
    end
    if (ctrl_wr) begin
      if (!(w_pgm && w_erase)) begin
        pgm_next = w_pgm && !erase_reg; // [R18]
        erase_next = w_erase && !pgm_reg; // [R18]
      end
      if (!hv_reg) begin
        mass_next = w_data_reg[CTRL_MASS_BIT];
      end
      if (state_reg == S_IDLE && (pgm_next || erase_next)) begin
        state_next = S_SEL; // [R02]
      end else if (!pgm_next && !erase_next && (pgm_reg || erase_reg)) begin
        if (state_reg == S_HV) begin
          state_next = S_HOLD; // [R09]
          tif.start = 1'b1;
          tif.load = HOLD_CYC;
        end else if (state_reg != S_HOLD && state_reg != S_RCV) begin
          state_next = S_IDLE;
        end
      end
      if (w_hv && !hv_reg) begin
        if (state_reg == S_ROW && (pgm_reg || erase_reg) && !locked) begin
          hv_next = 1'b1; // [R17] [R20]
          state_next = S_HV;
          tif.start = 1'b1;
          tif.load = PGS_CYC;
        end else begin
          refused_next = 1'b1; // [R11] [R17] [R20]
        end
      end else if (!w_hv && hv_reg) begin
        hv_next = 1'b0; // [R09]
        state_next = S_RCV;
        tif.start = 1'b1;
        tif.load = RCV_CYC;
      end
    end
    if (state_reg == S_RCV && !tif.busy && !tif.start) begin
      state_next = (pgm_reg || erase_reg) ? S_SEL : S_IDLE; // [R09]
    end
  end

  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      state_reg <= S_IDLE;
      pgm_reg <= 1'b0;
      erase_reg <= 1'b0;
      mass_reg <= 1'b0;
      hv_reg <= 1'b0;
      row_reg <= '0;
      arr_addr_reg <= '0;
      arr_data_reg <= ERASED_BYTE;
      refused_reg <= 1'b0;
      stb_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pgm_reg <= pgm_next;
      erase_reg <= erase_next;
      mass_reg <= mass_next;
      hv_reg <= hv_next;
      row_reg <= row_next;
      arr_addr_reg <= arr_addr_next;
      arr_data_reg <= arr_data_next;
      refused_reg <= refused_next;
      stb_reg <= stb_next;
    end
  end

  // array side outputs
  assign ARRAY_ADDR_OUT = arr_addr_reg;
  assign ARRAY_DATA_OUT = arr_data_reg;
  assign ARRAY_WRITE_STB_OUT = stb_reg;
  assign PROGRAM_SELECT_OUT = pgm_reg;
  assign ERASE_SELECT_OUT = erase_reg;
  assign MASS_SELECT_OUT = mass_reg;
  assign HIGH_VOLTAGE_ENABLE_OUT = hv_reg;
  assign ARRAY_READABLE_OUT = !hv_reg && (state_reg != S_RCV); // [R09]

endmodule : frpp_top

// ==== common/frpp_pkg.sv ====
// package: register map, field layout, timing and state encoding of the flash sequencer
package frpp_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int AXI_ADDR_W = 8;
  localparam int FL_ADDR_W = 16;
  localparam int FL_DATA_W = 8;
  localparam int TMR_W = 11;

  ////////////////////////////////////////////////////////////////////////////////
  // register offsets and word alignment
  localparam logic [AXI_ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] OFF_STATUS = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] OFF_PROTECT = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] OFF_FLASH_WR = 8'h0C;
  localparam logic [AXI_ADDR_W-1:0] WORD_MASK = 8'hFC;

  // flash_control_reg bits
  localparam int CTRL_PGM_BIT = 0;
  localparam int CTRL_ERASE_BIT = 1;
  localparam int CTRL_MASS_BIT = 2;
  localparam int CTRL_HV_BIT = 3;

  // status bits
  localparam int ST_STATE_LSB = 0;
  localparam int ST_BUSY_BIT = 3;
  localparam int ST_REFUSED_BIT = 4;
  localparam int ST_READY_BIT = 5;
  localparam int ST_TESTV_BIT = 6;

  // flash write word layout
  localparam int FW_ADDR_LSB = 0;
  localparam int FW_DATA_LSB = 16;
  localparam logic [3:0] FW_STRB_NEED = 4'h7;

  ////////////////////////////////////////////////////////////////////////////////
  // array geometry and protection
  localparam int ROW_LSB = 5;
  localparam logic [1:0] PROT_TOP_BITS = 2'h3;
  localparam logic [5:0] PROT_LOW_ZERO = 6'h00;
  localparam logic [7:0] PROT_ALL_OPEN = 8'hFF;
  localparam logic [7:0] PROT_ALL_LOCK = 8'h00;
  localparam logic [15:0] LOW_BLOCK_LO = 16'hBC00;
  localparam logic [15:0] LOW_BLOCK_HI = 16'hBFFF;
  localparam logic [15:0] PROTECT_BYTE_ADDR = 16'hFFBE;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////////
  // timing: figures in microseconds, counts derived from the bus clock
  localparam int CLK_PERIOD_NS = 25;
  localparam int NS_PER_US = 1000;
  localparam int SETUP_DELAY_US = 10;
  localparam int PROGRAM_SETUP_DELAY_US = 5;
  localparam int BYTE_PROGRAM_TIME_US = 30;
  localparam int HOLD_DELAY_US = 5;
  localparam int READ_RECOVERY_DELAY_US = 1;

  // least time rounded up to whole cycles, never below one
  function automatic logic [TMR_W-1:0] us_to_cycles_min(input int us);
    int c;
    c = (us * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) begin
      c = 1;
    end
    return c[TMR_W-1:0];
  endfunction : us_to_cycles_min

  localparam logic [TMR_W-1:0] SETUP_CYC = us_to_cycles_min(SETUP_DELAY_US);
  localparam logic [TMR_W-1:0] PGS_CYC = us_to_cycles_min(PROGRAM_SETUP_DELAY_US);
  localparam logic [TMR_W-1:0] PROG_CYC = us_to_cycles_min(BYTE_PROGRAM_TIME_US);
  localparam logic [TMR_W-1:0] HOLD_CYC = us_to_cycles_min(HOLD_DELAY_US);
  localparam logic [TMR_W-1:0] RCV_CYC = us_to_cycles_min(READ_RECOVERY_DELAY_US);

  ////////////////////////////////////////////////////////////////////////////////
  // bus responses and sequencer states (gray from idle through recovery, two bits change from recovery back to idle)
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_SEL = 3'h1,
    S_PREAD = 3'h3,
    S_ROW = 3'h2,
    S_HV = 3'h6,
    S_HOLD = 3'h7,
    S_RCV = 3'h5
  } frpp_state_t;

endpackage : frpp_pkg

// ==== common/frpp_tmr_if.sv ====
// interface: start, load value and busy between sequencer and interval timer
interface frpp_tmr_if;
  import frpp_pkg::*;
  logic start;
  logic [TMR_W-1:0] load;
  logic busy;
  modport ctl (output start, output load, input busy);
  modport tmr (input start, input load, output busy);
endinterface : frpp_tmr_if

// ==== design/frpp_timer.sv ====
// module: down-counting interval timer for the flash sequence waits
module frpp_timer (
  input wire logic clk_in,
  input wire logic rst_in,
  frpp_tmr_if.tmr tif
);
  import frpp_pkg::*;

  logic [TMR_W-1:0] count_reg;
  logic [TMR_W-1:0] count_next;

  ////////////////////////////////////////////////////////////////////////////////
  // reload on start, otherwise count down to zero
  always_comb begin
    count_next = count_reg;
    if (tif.start) begin
      count_next = tif.load;
    end else if (count_reg != '0) begin
      count_next = count_reg - TMR_W'(1);
    end
  end

  // count register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign tif.busy = (count_reg != '0);

endmodule : frpp_timer

// ==== verification/frpp_props.sv ====
// checker: properties on the sequencer's top ports
module frpp_props (
  input wire logic REF_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic AXI_BVALID_OUT,
  input wire logic AXI_BREADY_IN,
  input wire logic [1:0] AXI_BRESP_OUT,
  input wire logic [frpp_pkg::FL_DATA_W-1:0] PROTECT_START_BYTE_IN,
  input wire logic TEST_HIGH_VOLTAGE_IN,
  input wire logic [frpp_pkg::FL_ADDR_W-1:0] ARRAY_ADDR_OUT,
  input wire logic ARRAY_WRITE_STB_OUT,
  input wire logic PROGRAM_SELECT_OUT,
  input wire logic ERASE_SELECT_OUT,
  input wire logic HIGH_VOLTAGE_ENABLE_OUT,
  input wire logic ARRAY_READABLE_OUT
);
  import frpp_pkg::*;
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  ////////////////////////////////////////////////////////////////////////////////
  // row address, frozen while high voltage is on
  logic [10:0] row_reg, row_next;
  always_comb begin
    row_next = HIGH_VOLTAGE_ENABLE_OUT ? row_reg : ARRAY_ADDR_OUT[15:ROW_LSB];
  end
  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      row_reg <= '0;
    end else begin
      row_reg <= row_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // high voltage on without test voltage
  sequence hv_up_plain;
    $rose(HIGH_VOLTAGE_ENABLE_OUT) && !TEST_HIGH_VOLTAGE_IN && !$past(TEST_HIGH_VOLTAGE_IN, 6);
  endsequence
  sequence hv_drop;
    $fell(HIGH_VOLTAGE_ENABLE_OUT);
  endsequence
  // unreadable through recovery, then readable
  sequence recover;
    (!ARRAY_READABLE_OUT) [*8] ##30 !ARRAY_READABLE_OUT ##[1:12] ARRAY_READABLE_OUT;
  endsequence

  a_sel_interlock: assert property (!(PROGRAM_SELECT_OUT && ERASE_SELECT_OUT))
    else $error("program and erase select both set");
  a_hv_needs_sel: assert property ($rose(HIGH_VOLTAGE_ENABLE_OUT) |->
    PROGRAM_SELECT_OUT || ERASE_SELECT_OUT)
    else $error("high voltage rose without a select bit");
  a_hv_lock_all: assert property (hv_up_plain |-> PROTECT_START_BYTE_IN != PROT_ALL_LOCK)
    else $error("high voltage rose with every address locked");
  a_hv_low_block: assert property (hv_up_plain ##0 (ARRAY_ADDR_OUT >= LOW_BLOCK_LO &&
    ARRAY_ADDR_OUT <= LOW_BLOCK_HI) |-> PROTECT_START_BYTE_IN == PROT_ALL_OPEN)
    else $error("high voltage rose inside the low locked block");
  a_hv_range: assert property (hv_up_plain ##0 (PROTECT_START_BYTE_IN != PROT_ALL_OPEN) |->
    ARRAY_ADDR_OUT < {PROT_TOP_BITS, PROTECT_START_BYTE_IN, PROT_LOW_ZERO})
    else $error("high voltage rose inside the protected range");
  a_stb_in_prog: assert property (ARRAY_WRITE_STB_OUT |->
    HIGH_VOLTAGE_ENABLE_OUT && PROGRAM_SELECT_OUT)
    else $error("byte strobe outside a program phase");
  a_stb_pulse: assert property (ARRAY_WRITE_STB_OUT |=> !ARRAY_WRITE_STB_OUT)
    else $error("byte strobe longer than one cycle");
  a_stb_row: assert property (ARRAY_WRITE_STB_OUT |-> ARRAY_ADDR_OUT[15:ROW_LSB] == row_reg)
    else $error("byte strobe outside the selected row");
  a_hv_unread: assert property (HIGH_VOLTAGE_ENABLE_OUT |-> !ARRAY_READABLE_OUT)
    else $error("array readable with high voltage on");
  a_read_recover: assert property (hv_drop |-> recover)
    else $error("array recovery time wrong");
  a_bresp_hold: assert property (AXI_BVALID_OUT && !AXI_BREADY_IN |=>
    AXI_BVALID_OUT && $stable(AXI_BRESP_OUT))
    else $error("write response dropped before taken");
endmodule : frpp_props

bind frpp_top frpp_props u_props (.*);

// ==== verification/frpp_top_tb.sv ====
// testbench: register sequences and checks of the sequencer
module frpp_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import frpp_pkg::*;
  logic clk = 1'b0, rst = 1'b1, tst = 1'b0;
  logic awv = 1'b0, wv = 1'b0, br = 1'b1, arv = 1'b0, rr = 1'b1;
  logic [7:0] awa = 8'h00, ara = 8'h00, prot = 8'hFF;
  logic [31:0] wd = 32'h0, rd;
  logic [3:0] ws = 4'h0;
  logic awr, wr, bv, arr, rv, stb, program_select, ers, mas, hv, rdy;
  logic [1:0] bresp, rresp;
  logic [15:0] fa, stb_a;
  logic [7:0] fd, stb_d;
  int bad_count = 0, total_checks = 0, stb_n = 0;
  // cases: byte, address, test voltage bit 4, mode
  logic [31:0] tbl [12] = '{32'hFFC04001, 32'h01C02001, 32'h01C04001, 32'hFEFF6001,
    32'hFEFF8001, 32'h7FC00001, 32'h7FBFE001, 32'h00C00001, 32'h00C00011, 32'h01C04002,
    32'hFFBC0002, 32'hFEC04006};

  frpp_top u_dut (.REF_CLK_IN(clk), .SYS_RST_IN(rst), .AXI_AWVALID_IN(awv),
    .AXI_AWREADY_OUT(awr), .AXI_AWADDR_IN(awa), .AXI_WVALID_IN(wv), .AXI_WREADY_OUT(wr),
    .AXI_WDATA_IN(wd), .AXI_WSTRB_IN(ws), .AXI_BVALID_OUT(bv), .AXI_BREADY_IN(br),
    .AXI_BRESP_OUT(bresp), .AXI_ARVALID_IN(arv), .AXI_ARREADY_OUT(arr),
    .AXI_ARADDR_IN(ara), .AXI_RVALID_OUT(rv), .AXI_RREADY_IN(rr), .AXI_RDATA_OUT(rd),
    .AXI_RRESP_OUT(rresp), .PROTECT_START_BYTE_IN(prot), .TEST_HIGH_VOLTAGE_IN(tst),
    .ARRAY_ADDR_OUT(fa), .ARRAY_DATA_OUT(fd), .ARRAY_WRITE_STB_OUT(stb),
    .PROGRAM_SELECT_OUT(program_select), .ERASE_SELECT_OUT(ers), .MASS_SELECT_OUT(mas),
    .HIGH_VOLTAGE_ENABLE_OUT(hv), .ARRAY_READABLE_OUT(rdy));

  ////////////////////////////////////////////////////////////////////////////////
  // clock and strobe monitor
  always #12.5 clk = ~clk;
  always @(negedge clk) begin
    if (stb === 1'b1) begin
      stb_n++;
      stb_a = fa;
      stb_d = fd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // verdict, comparison and bounded wait
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(inout int n);
    n++;
    if (n > 300) begin
      bad_count++;
      $display("CHECK FAILED handshake expected answer seen timeout");
      wrap_up();
    end
  endtask : tick

  // bus write: address and data together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
    int n;
    logic ta, tw, tb;
    logic [1:0] q;
    n = 0;
    tb = 1'b0;
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    ws <= s;
    while (!tb) begin
      @(negedge clk);
      ta = awv & awr;
      tw = wv & wr;
      tb = bv & br;
      q = bresp;
      @(posedge clk);
      if (ta) begin
        awv <= 1'b0;
      end
      if (tw) begin
        wv <= 1'b0;
      end
      tick(n);
    end
    chk("bresp", {30'h0, er}, {30'h0, q});
  endtask : axw
  // bus read: masked data and response compared
  task automatic axr(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                     input logic [1:0] er);
    int n;
    logic ta, tr;
    logic [31:0] q;
    logic [1:0] p;
    n = 0;
    tr = 1'b0;
    arv <= 1'b1;
    ara <= a;
    while (!tr) begin
      @(negedge clk);
      ta = arv & arr;
      tr = rv & rr;
      q = rd;
      p = rresp;
      @(posedge clk);
      if (ta) begin
        arv <= 1'b0;
      end
      tick(n);
    end
    chk("rdata", e, q & m);
    chk("rresp", {30'h0, er}, {30'h0, p});
  endtask : axr

  // full select sequence, then high voltage request against the lock model
  task automatic try_hv(input logic [31:0] e);
    logic [7:0] p;
    logic [15:0] a;
    logic [2:0] md;
    logic t, lk;
    p = e[31:24];
    a = e[23:8];
    t = e[4];
    md = e[2:0];
    lk = !t && p != 8'hFF && (p == 8'h00 || md[2] || a >= {2'h3, p, 6'h00} ||
         (a >= 16'hBC00 && a <= 16'hBFFF));
    prot <= p;
    tst <= t;
    repeat (6) @(posedge clk);
    axw(OFF_CTRL, {29'h0, md}, 4'h1, RESP_OKAY);
    axr(OFF_PROTECT, 32'hFF, {24'h0, p}, RESP_OKAY);
    axw(OFF_FLASH_WR, {8'h0, 8'h5A, a}, 4'h7, RESP_OKAY);
    if (md[1]) begin
      @(negedge clk);
      chk("erase data", 32'hFF, {24'h0, fd});
      @(posedge clk);
    end
    axw(OFF_CTRL, {29'h1, md}, 4'h1, RESP_OKAY);
    axr(OFF_STATUS, 32'h10, {27'h0, lk, 4'h0}, RESP_OKAY);
    chk("hv", {31'h0, !lk}, {31'h0, hv});
    axw(OFF_CTRL, lk ? 32'h0 : 32'h8, 4'h1, RESP_OKAY);
    repeat (210) @(posedge clk);
    axw(OFF_CTRL, 32'h0, 4'h1, RESP_OKAY);
    axw(OFF_STATUS, 32'h10, 4'h1, RESP_OKAY);
    repeat (50) @(posedge clk);
  endtask : try_hv

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [15:0] r, o;
    logic [7:0] d;
    int n0;
    void'($urandom(6191));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("reset data", 32'hFF, {24'h0, fd});
    axr(OFF_CTRL, 32'hF, 32'h0, RESP_OKAY);
    axr(OFF_STATUS, 32'h7F, 32'h20, RESP_OKAY);
    axr(8'h10, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
    axw(8'h10, 32'h1, 4'hF, RESP_SLVERR);
    axw(OFF_PROTECT, 32'h0, 4'hF, RESP_SLVERR);
    axr(OFF_PROTECT, 32'hFF, 32'hFF, RESP_OKAY);
    // select interlock: both at once, then one over the other
    axw(OFF_CTRL, 32'h3, 4'h1, RESP_OKAY);
    axr(OFF_CTRL, 32'h3, 32'h0, RESP_OKAY);
    axw(OFF_CTRL, 32'h1, 4'h1, RESP_OKAY);
    axw(OFF_CTRL, 32'h2, 4'h1, RESP_OKAY);
    axr(OFF_CTRL, 32'h3, 32'h0, RESP_OKAY);
    // high voltage with steps missing
    axw(OFF_CTRL, 32'h1, 4'h1, RESP_OKAY);
    axw(OFF_CTRL, 32'h9, 4'h1, RESP_OKAY);
    axr(OFF_PROTECT, 32'hFF, 32'hFF, RESP_OKAY);
    axw(OFF_CTRL, 32'h9, 4'h1, RESP_OKAY);
    axr(OFF_CTRL, 32'hF, 32'h1, RESP_OKAY);
    axr(OFF_STATUS, 32'h10, 32'h10, RESP_OKAY);
    axw(OFF_CTRL, 32'h0, 4'h1, RESP_OKAY);
    axw(OFF_STATUS, 32'h10, 4'h1, RESP_OKAY);
    axr(OFF_STATUS, 32'h10, 32'h0, RESP_OKAY);
    // random row programmed, last write outside it
    r = 16'hC000 + 16'($urandom_range(255)) * 16'd32;
    axw(OFF_CTRL, 32'h1, 4'h1, RESP_OKAY);
    axr(OFF_PROTECT, 32'hFF, 32'hFF, RESP_OKAY);
    axw(OFF_FLASH_WR, {8'h0, 8'h00, r + 16'd7}, 4'h7, RESP_OKAY);
    repeat (SETUP_DELAY_US * 40) @(posedge clk);
    axw(OFF_CTRL, 32'h9, 4'h1, RESP_OKAY);
    axr(OFF_STATUS, 32'h7, {29'h0, S_HV}, RESP_OKAY);
    repeat (PROGRAM_SETUP_DELAY_US * 40) @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      o = (k == 3) ? 16'd32 : 16'($urandom_range(31));
      d = 8'($urandom);
      n0 = stb_n;
      axw(OFF_FLASH_WR, {8'h0, d, r + o}, 4'h7, RESP_OKAY);
      repeat (3) @(posedge clk);
      chk("strobes", n0 + (k < 3), stb_n);
      if (k < 3) begin
        chk("byte addr", {16'h0, r + o}, {16'h0, stb_a});
        chk("byte data", {24'h0, d}, {24'h0, stb_d});
      end
      repeat (BYTE_PROGRAM_TIME_US * 40) @(posedge clk);
    end
    axr(OFF_STATUS, 32'h10, 32'h10, RESP_OKAY);
    axw(OFF_CTRL, 32'h8, 4'h1, RESP_OKAY);
    repeat (HOLD_DELAY_US * 40) @(posedge clk);
    axw(OFF_CTRL, 32'h0, 4'h1, RESP_OKAY);
    @(negedge clk);
    chk("readable", 32'h0, {31'h0, rdy});
    repeat (READ_RECOVERY_DELAY_US * 40 + 5) @(negedge clk);
    chk("readable", 32'h1, {31'h0, rdy});
    @(posedge clk);
    axw(OFF_STATUS, 32'h10, 4'h1, RESP_OKAY);
    // protection table
    foreach (tbl[i]) begin
      try_hv(tbl[i]);
    end
    wrap_up();
  end
endmodule : frpp_top_tb
